/* include/tecu_pkg.sv */
// Package of constants and types for the timer and event counter unit
package tecu_pkg;

  // ***********************************
  // Sizes
  // ***********************************
  localparam int NCH = 6;
  localparam int NFIRST = 5;
  localparam int CW = 16;
  localparam int PRE_W = 9;

  // ***********************************
  // Register map (byte addresses)
  // ***********************************
  localparam logic [7:0] ADDR_START = 8'h00;
  localparam logic [7:0] ADDR_UPDOWN = 8'h04;
  localparam logic [7:0] ADDR_IRQ = 8'h08;
  localparam logic [7:0] ADDR_CH_BASE = 8'h10;
  localparam logic [7:0] ADDR_CH_STRIDE = 8'h08;
  localparam logic [7:0] ADDR_TIMER_OFS = 8'h04;

  // ***********************************
  // Mode register fields
  // ***********************************
  localparam int MODE_LO = 0;
  localparam int MODE_HI = 1;
  localparam int MODE_OUT_EN = 2;
  localparam int MODE_POL = 3;
  localparam int MODE_GATE = 4;
  localparam int MODE_CLK_LO = 6;
  localparam int MODE_CLK_HI = 7;

  // ***********************************
  // Reset values
  // ***********************************
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [CW-1:0] CNT_RST = 16'h0000;
  localparam logic [CW-1:0] CNT_TOP = 16'hFFFF;
  localparam logic [NCH-1:0] FLAGS_RST = 6'h00;

  // ***********************************
  // Count source dividers: tick when low prescaler bits are all ones
  // ***********************************
  localparam logic [PRE_W-1:0] DIV2_MASK = 9'h001;
  localparam logic [PRE_W-1:0] DIV8_MASK = 9'h007;
  localparam logic [PRE_W-1:0] DIV32_MASK = 9'h01F;
  localparam logic [PRE_W-1:0] DIV512_MASK = 9'h1FF;

  typedef enum logic [1:0] {
    TECU_TIMER,
    TECU_EVENT,
    TECU_ONESHOT,
    TECU_PWM
  } tecu_mode_e;

  typedef struct packed {
    logic [7:0] mode;
    logic start;
    logic updown;
  } tecu_cfg_s;

endpackage

/* src/tecu_channel.sv */
// One counter channel: timer mode and event counter mode
`timescale 1ns/1ns
module tecu_channel #(
  parameter bit FIRST_TYPE = 1'b1
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire tecu_pkg::tecu_cfg_s cfg_in,
  input wire logic [3:0] pre_ticks_in,
  input wire logic input_pin_in,
  input wire logic dir_pin_in,
  input wire logic wr_en_in,
  input wire logic [15:0] wr_data_in,
  output logic [15:0] cnt_out,
  output logic [15:0] reload_out,
  output logic term_out,
  output logic pin_out,
  output logic pin_oe_out
);

  logic [15:0] cnt_ff;
  logic [15:0] reload_ff;
  logic in_prev_ff;
  logic pin_ff;
  logic oe_ff;
  tecu_pkg::tecu_mode_e mode_e;
  logic is_timer;
  logic is_event;
  logic edge_seen;
  logic gate_ok;
  logic count_up;
  logic step;
  logic at_end;

  // ***********************************
  // Step decode
  // ***********************************
  // Second-type channel only knows timer mode
  assign mode_e = FIRST_TYPE ?
    tecu_pkg::tecu_mode_e'(cfg_in.mode[tecu_pkg::MODE_HI:tecu_pkg::MODE_LO]) :
    tecu_pkg::TECU_TIMER;
  assign is_timer = (mode_e == tecu_pkg::TECU_TIMER);
  assign is_event = (mode_e == tecu_pkg::TECU_EVENT);
  // Falling edge when polarity bit low, rising when high
  assign edge_seen = cfg_in.mode[tecu_pkg::MODE_POL] ?
    (input_pin_in & ~in_prev_ff) : (~input_pin_in & in_prev_ff);
  assign gate_ok = ~cfg_in.mode[tecu_pkg::MODE_GATE] |
    (input_pin_in == cfg_in.mode[tecu_pkg::MODE_POL]);
  assign count_up = is_event & (cfg_in.mode[tecu_pkg::MODE_GATE] ?
    dir_pin_in : cfg_in.updown);
  assign step = cfg_in.start & ((is_timer & gate_ok &
    pre_ticks_in[cfg_in.mode[tecu_pkg::MODE_CLK_HI:tecu_pkg::MODE_CLK_LO]]) |
    (is_event & edge_seen));
  assign at_end = count_up ? (cnt_ff == tecu_pkg::CNT_TOP) :
    (cnt_ff == tecu_pkg::CNT_RST);
  // Reload on the step that finds the end value gives n+1 steps
  assign term_out = step & at_end;

  // ***********************************
  // Counter and reload storage
  // ***********************************
  // Stopped write loads both; running write waits for next reload
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt_ff <= tecu_pkg::CNT_RST;
    end else if (wr_en_in && !cfg_in.start) begin
      cnt_ff <= wr_data_in;
    end else if (term_out) begin
      cnt_ff <= reload_ff;
    end else if (step) begin
      cnt_ff <= count_up ? cnt_ff + 16'h0001 : cnt_ff - 16'h0001;
    end
  end

  // Kept apart from the counter
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      reload_ff <= tecu_pkg::CNT_RST;
    end else if (wr_en_in) begin
      reload_ff <= wr_data_in;
    end
  end

  // Previous pin level for edge detection
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      in_prev_ff <= 1'b0;
    end else begin
      in_prev_ff <= input_pin_in;
    end
  end

  // ***********************************
  // Pulse output
  // ***********************************
  // Low while stopped, toggles at each end value
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pin_ff <= 1'b0;
    end else if (!cfg_in.start) begin
      pin_ff <= 1'b0;
    end else if (term_out) begin
      pin_ff <= ~pin_ff;
    end
  end

  // Pin is a plain port pin unless output is enabled in timer or event mode
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= cfg_in.mode[tecu_pkg::MODE_OUT_EN] & (is_timer | is_event);
    end
  end

  assign cnt_out = cnt_ff;
  assign reload_out = reload_ff;
  assign pin_out = pin_ff;
  assign pin_oe_out = oe_ff;

endmodule

/* src/tecu_top.sv */
// Timer and event counter unit with APB register access
// How it works
// - Six 16-bit channels, five first type, one second type; pins shared with ports.
// - Mode bits 1:0 decode: 00 timer mode, 01 event counter mode.
// - Timer mode: bits 7:6 pick count clock; count only while start flag set.
// - Timer mode decrements; at 0000 set request, reload, keep counting.
// - Bit 2 set: output toggles at 0000, low while stopped.
// - Bit 4 set: count only while input at level chosen by bit 3.
// - Stopped write loads reload and counter; running write only reload; counter readable.
// - Programmed value n divides count source by n plus one.
// - Event mode counts input falling edges, or rising when bit 3 set.
// - Event mode, bit 4 clear: up-down flag zero decrements, one increments.
// - Event mode, bit 4 set: output pin level low decrements, high increments.
// - Event mode: at 0000 down or FFFF up, request, reload, continue.
// - Event mode with bit 2 set: output inverts at each end value.
// - Request bits clear on reset, on service, or by software.
`timescale 1ns/1ns
module tecu_top (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [5:0] channel_input_pin_in,
  input wire logic [5:0] channel_output_pin_in,
  output logic [5:0] channel_output_pin_out,
  output logic [5:0] channel_output_pin_oe_out,
  input wire logic [5:0] irq_ack_in,
  output logic [5:0] irq_req_out
);

  // ***********************************
  // Declarations
  // ***********************************
  logic [tecu_pkg::NCH-1:0] start_ff;
  logic [tecu_pkg::NCH-1:0] updown_ff;
  logic [tecu_pkg::NCH-1:0] irq_ff;
  logic [7:0] mode_ff [tecu_pkg::NCH];
  logic [tecu_pkg::PRE_W-1:0] pre_ff;
  logic [3:0] pre_ticks;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic setup;
  logic access;
  logic wr_acc;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [15:0] cnt_w [tecu_pkg::NCH];
  logic [15:0] reload_w [tecu_pkg::NCH];
  logic [tecu_pkg::NCH-1:0] term_w;
  logic [tecu_pkg::NCH-1:0] pin_w;
  logic [tecu_pkg::NCH-1:0] oe_w;
  logic [tecu_pkg::NCH-1:0] tmr_wr;
  logic [tecu_pkg::NCH-1:0] irq_wclr;

  // Byte address of a channel's mode or timer word
  function automatic logic ch_addr_is(input logic [7:0] a, input int i, input logic tmr);
    logic [7:0] base;
    base = tecu_pkg::ADDR_CH_BASE + 8'(i) * tecu_pkg::ADDR_CH_STRIDE;
    ch_addr_is = (a == (tmr ? base + tecu_pkg::ADDR_TIMER_OFS : base));
  endfunction

  // ***********************************
  // APB slave
  // ***********************************
  assign setup = psel_in & ~penable_in;
  assign access = psel_in & penable_in & pready_ff;
  assign wr_acc = access & pwrite_in & ~pslverr_ff;

  // One wait-free access phase after every setup cycle
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
    end
  end

  // Unmapped addresses answer with an error
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= setup & ~rd_hit;
    end
  end

  // Read data sampled in setup so the output comes from a flop
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      prdata_ff <= 32'h00000000;
    end else if (setup) begin
      prdata_ff <= pwrite_in ? 32'h00000000 : rd_word;
    end
  end

  // Address decode and read mux; counter is always readable
  always_comb begin
    rd_word = 32'h00000000;
    rd_hit = 1'b0;
    if (paddr_in == tecu_pkg::ADDR_START) begin
      rd_word = {26'h0000000, start_ff};
      rd_hit = 1'b1;
    end else if (paddr_in == tecu_pkg::ADDR_UPDOWN) begin
      rd_word = {26'h0000000, updown_ff};
      rd_hit = 1'b1;
    end else if (paddr_in == tecu_pkg::ADDR_IRQ) begin
      rd_word = {26'h0000000, irq_ff};
      rd_hit = 1'b1;
    end else begin
      for (int i = 0; i < tecu_pkg::NCH; i++) begin
        if (ch_addr_is(paddr_in, i, 1'b0)) begin
          rd_word = {24'h000000, mode_ff[i]};
          rd_hit = 1'b1;
        end else if (ch_addr_is(paddr_in, i, 1'b1)) begin
          rd_word = {16'h0000, cnt_w[i]};
          rd_hit = 1'b1;
        end
      end
    end
  end

  // ***********************************
  // Global flags
  // ***********************************
  // Count start flags steer every channel
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      start_ff <= tecu_pkg::FLAGS_RST;
    end else if (wr_acc && paddr_in == tecu_pkg::ADDR_START) begin
      start_ff <= pwdata_in[tecu_pkg::NCH-1:0];
    end
  end

  // Up-down flags for event counting
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      updown_ff <= tecu_pkg::FLAGS_RST;
    end else if (wr_acc && paddr_in == tecu_pkg::ADDR_UPDOWN) begin
      updown_ff <= pwdata_in[tecu_pkg::NCH-1:0];
    end
  end

  // Write one to clear, service also clears; a new end value wins
  assign irq_wclr = (wr_acc && paddr_in == tecu_pkg::ADDR_IRQ) ?
    pwdata_in[tecu_pkg::NCH-1:0] : tecu_pkg::FLAGS_RST;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      irq_ff <= tecu_pkg::FLAGS_RST;
    end else begin
      irq_ff <= (irq_ff & ~(irq_wclr | irq_ack_in)) | term_w;
    end
  end

  // ***********************************
  // Count source prescaler
  // ***********************************
  // Free running so all channels share one divider
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + 9'h001;
    end
  end

  // One-cycle enables for each selectable count source
  assign pre_ticks[0] = (pre_ff & tecu_pkg::DIV2_MASK) == tecu_pkg::DIV2_MASK;
  assign pre_ticks[1] = (pre_ff & tecu_pkg::DIV8_MASK) == tecu_pkg::DIV8_MASK;
  assign pre_ticks[2] = (pre_ff & tecu_pkg::DIV32_MASK) == tecu_pkg::DIV32_MASK;
  assign pre_ticks[3] = (pre_ff & tecu_pkg::DIV512_MASK) == tecu_pkg::DIV512_MASK;

  // ***********************************
  // Channels
  // ***********************************
  genvar g;
  generate
    for (g = 0; g < tecu_pkg::NCH; g++) begin : gen_ch
      tecu_pkg::tecu_cfg_s cfg;
      // One driver for the whole carrier struct
      assign cfg = '{mode: mode_ff[g], start: start_ff[g],
        updown: updown_ff[g]};
      assign tmr_wr[g] = wr_acc & ch_addr_is(paddr_in, g, 1'b1);

      // Mode register per channel
      always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
          mode_ff[g] <= tecu_pkg::MODE_RST;
        end else if (wr_acc && ch_addr_is(paddr_in, g, 1'b0)) begin
          mode_ff[g] <= pwdata_in[7:0];
        end
      end

      // Last channel is the second type, timer mode only
      tecu_channel #(
        .FIRST_TYPE(g < tecu_pkg::NFIRST)
      ) u_ch (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .cfg_in(cfg),
        .pre_ticks_in(pre_ticks),
        .input_pin_in(channel_input_pin_in[g]),
        .dir_pin_in(channel_output_pin_in[g]),
        .wr_en_in(tmr_wr[g]),
        .wr_data_in(pwdata_in[15:0]),
        .cnt_out(cnt_w[g]),
        .reload_out(reload_w[g]),
        .term_out(term_w[g]),
        .pin_out(pin_w[g]),
        .pin_oe_out(oe_w[g])
      );

      // Stopped write reaches the counter on the next edge
      a_stopped_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        tmr_wr[g] && !start_ff[g] |=> cnt_w[g] == $past(pwdata_in[15:0]))
        else $error("stopped write did not load counter");

      // Running write lands in reload, counter not forced
      a_running_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        tmr_wr[g] && start_ff[g] |=> reload_w[g] == $past(pwdata_in[15:0]))
        else $error("running write did not load reload");

      // End value reload and request flag
      a_end_reload: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        term_w[g] && !tmr_wr[g] |=> cnt_w[g] == $past(reload_w[g]) && irq_ff[g])
        else $error("end value did not reload and request");

      // Timer mode down step on a selected tick
      a_timer_step: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        start_ff[g] && mode_ff[g][1:0] == 2'b00 && !mode_ff[g][4] && !tmr_wr[g] &&
        pre_ticks[mode_ff[g][7:6]] && cnt_w[g] != 16'h0000
        |=> cnt_w[g] == $past(cnt_w[g]) - 16'h0001)
        else $error("timer did not decrement");

      // Gate at the wrong level holds the counter
      a_gate_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        mode_ff[g][1:0] == 2'b00 && mode_ff[g][4] && !tmr_wr[g] &&
        channel_input_pin_in[g] != mode_ff[g][3] |=> $stable(cnt_w[g]))
        else $error("gated timer counted");

      // Stopped channel never counts
      a_stop_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !start_ff[g] && !tmr_wr[g] |=> $stable(cnt_w[g]))
        else $error("stopped channel counted");

      // Output low two edges after a stop
      a_out_low: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !start_ff[g] ##1 !start_ff[g] |=> !channel_output_pin_out[g])
        else $error("output not low while stopped");

      // Output inverts on every end value
      a_out_toggle: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        term_w[g] && start_ff[g] |=> pin_w[g] != $past(pin_w[g]))
        else $error("output did not toggle");
    end
  endgenerate

  // Event mode up count follows the up-down flag
  a_event_up: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    start_ff[2] && mode_ff[2][1:0] == 2'b01 && !mode_ff[2][4] && updown_ff[2] &&
    !tmr_wr[2] && !term_w[2] && mode_ff[2][3] && channel_input_pin_in[2] &&
    !$past(channel_input_pin_in[2]) |=> cnt_w[2] == $past(cnt_w[2]) + 16'h0001)
    else $error("event counter did not increment");

  // Service clears a request unless a new end value arrives
  a_irq_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    irq_ack_in[2] && !term_w[2] |=> !irq_ff[2])
    else $error("request not cleared by service");

  // Access phase lasts exactly one cycle
  a_pready_pulse: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    setup |=> pready_out ##1 !pready_out || setup)
    else $error("pready not a single cycle answer");

  // ***********************************
  // Outputs
  // ***********************************
  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign irq_req_out = irq_ff;
  assign channel_output_pin_out = pin_w;
  assign channel_output_pin_oe_out = oe_w;

endmodule

/* tb/tecu_pin_model.sv */
// Pin-side model: event sources, gate levels and direction levels
`timescale 1ns/1ns
module tecu_pin_model (
  input wire logic clk_sys_in,
  input wire logic [5:0] pin_drv_in,
  input wire logic [5:0] pin_oe_in,
  output logic [5:0] input_pin_out,
  output logic [5:0] out_wire_out
);
  logic [5:0] dir_lvl;

  // Quiet pins at time zero
  initial begin
    input_pin_out = 6'h00;
    dir_lvl = 6'h00;
  end

  // Resolved output-pin wire: the device wins while it drives
  assign out_wire_out = (pin_oe_in & pin_drv_in) | (~pin_oe_in & dir_lvl);

  // Direction level settles well before any counted edge
  task automatic set_dir(input int ch, input logic lvl);
    @(posedge clk_sys_in);
    dir_lvl[ch] <= lvl;
    repeat (4) @(posedge clk_sys_in);
  endtask

  // One level change, then held; callers keep gate levels long
  task automatic toggle_in(input int ch, input int hold);
    @(posedge clk_sys_in);
    input_pin_out[ch] <= ~input_pin_out[ch];
    repeat (hold) @(posedge clk_sys_in);
  endtask
endmodule

/* tb/tecu_top_test.sv */
// Self-checking bench for the timer and event counter unit
`timescale 1ns/1ns
module tecu_top_test;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [5:0] in_pin, out_wire, pin_drv, pin_oe, irq_req;
  logic [5:0] irq_ack = 6'h00;
  int failures = 0;
  int n_compared = 0;
  int seed = 32'h20a94a83;
  int divs[4] = '{2, 8, 32, 512};
  logic [32:0] exp_q[$];
  int cyc = 0;

  always #10 clk_sys_in = ~clk_sys_in;

  // Edge count, for periods that span a bus write
  always @(posedge clk_sys_in) cyc <= cyc + 1;

  tecu_top u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .channel_input_pin_in(in_pin), .channel_output_pin_in(out_wire),
    .channel_output_pin_out(pin_drv), .channel_output_pin_oe_out(pin_oe),
    .irq_ack_in(irq_ack), .irq_req_out(irq_req));

  tecu_pin_model u_pins (.clk_sys_in(clk_sys_in), .pin_drv_in(pin_drv),
    .pin_oe_in(pin_oe), .input_pin_out(in_pin), .out_wire_out(out_wire));

  // ***********************************
  // Reporting
  // ***********************************
  task automatic give_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ***********************************
  // APB master and read scoreboard
  // ***********************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys_in);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin
      failures++;
      $display("[FAIL] pready expected within 50 seen none");
      give_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // The expected word is noted before the request goes out
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic err);
    exp_q.push_back({err, d});
    apb(1'b0, a, 32'h0);
  endtask

  // Completed reads are matched to the oldest note
  always @(posedge clk_sys_in) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected read", 33'h0, {pslverr, prdata});
      else check("read data", exp_q.pop_front(), {pslverr, prdata});
    end
  end

  function automatic logic [7:0] mode_a(input int i);
    return tecu_pkg::ADDR_CH_BASE + tecu_pkg::ADDR_CH_STRIDE * i[7:0];
  endfunction

  function automatic logic [7:0] tmr_a(input int i);
    return mode_a(i) + tecu_pkg::ADDR_TIMER_OFS;
  endfunction

  // Cycles until the channel output changes, bounded
  task automatic wait_toggle(input int ch, output int n);
    logic last;
    last = pin_drv[ch];
    for (n = 1; n <= 4000; n++) begin
      @(posedge clk_sys_in);
      if (pin_drv[ch] !== last) return;
    end
    failures++;
    $display("[FAIL] output toggle expected within 4000 seen none");
    give_verdict();
  endtask

  // ***********************************
  // Main sequence
  // ***********************************
  initial begin
    logic [15:0] v;
    int n, k, c;
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    // Reset state, then stopped writes land in the counter
    rd(tecu_pkg::ADDR_START, 32'h0, 1'b0);
    rd(tecu_pkg::ADDR_UPDOWN, 32'h0, 1'b0);
    rd(tecu_pkg::ADDR_IRQ, 32'h0, 1'b0);
    for (int i = 0; i < tecu_pkg::NCH; i++) begin
      v = 16'($random(seed));
      rd(mode_a(i), 32'h0, 1'b0);
      wr(tmr_a(i), {16'h0000, v});
      rd(tmr_a(i), {16'h0000, v}, 1'b0);
    end
    rd(8'hFC, 32'h0, 1'b1);
    // Each count source with a random reload
    for (int s = 0; s < 4; s++) begin
      n = 1 + ($random(seed) & 3);
      wr(tmr_a(0), 32'(n));
      wr(mode_a(0), {24'h0, s[1:0], 6'h04});
      wr(tecu_pkg::ADDR_START, 32'h01);
      rd(tecu_pkg::ADDR_START, 32'h01, 1'b0);
      wait_toggle(0, k);
      wait_toggle(0, k);
      check("timer period", 33'((n + 1) * divs[s]), 33'(k));
      wr(tecu_pkg::ADDR_START, 32'h00);
      repeat (3) @(posedge clk_sys_in);
      check("stopped pin", 33'h2, {31'h0, pin_oe[0], pin_drv[0]});
    end
    rd(tecu_pkg::ADDR_IRQ, 32'h01, 1'b0);
    wr(tecu_pkg::ADDR_IRQ, 32'h01);
    rd(tecu_pkg::ADDR_IRQ, 32'h00, 1'b0);
    // A running write waits for the next reload
    wr(tmr_a(0), 32'd20);
    wr(mode_a(0), 32'h04);
    wr(tecu_pkg::ADDR_START, 32'h01);
    wait_toggle(0, k);
    c = cyc;
    wr(tmr_a(0), 32'd5);
    wait_toggle(0, k);
    check("old period kept", 33'd42, 33'(cyc - c));
    wait_toggle(0, k);
    check("new period", 33'd12, 33'(k));
    wr(tecu_pkg::ADDR_START, 32'h00);
    // Gated counting at both levels, 40 open cycles give 20 ticks
    for (int p = 0; p < 2; p++) begin
      if (in_pin[1] !== ~p[0]) u_pins.toggle_in(1, 8);
      wr(tmr_a(1), 32'h0100);
      wr(mode_a(1), {24'h0, 4'h1, p[0], 3'h0});
      wr(tecu_pkg::ADDR_START, 32'h02);
      repeat (40) @(posedge clk_sys_in);
      rd(tmr_a(1), 32'h0100, 1'b0);
      u_pins.toggle_in(1, 39);
      u_pins.toggle_in(1, 8);
      rd(tmr_a(1), 32'h00EC, 1'b0);
      wr(tecu_pkg::ADDR_START, 32'h00);
    end
    // Edge choice and up-down flag: five changes from low, three rises
    for (int m = 0; m < 4; m++) begin
      if (in_pin[2] !== 1'b0) u_pins.toggle_in(2, 6);
      wr(tmr_a(2), 32'h0010);
      wr(mode_a(2), {24'h0, 4'h0, m[0], 3'h1});
      wr(tecu_pkg::ADDR_UPDOWN, {29'h0, m[1], 2'h0});
      wr(tecu_pkg::ADDR_START, 32'h04);
      repeat (5) u_pins.toggle_in(2, 6);
      c = m[0] ? 3 : 2;
      rd(tmr_a(2), m[1] ? 32'(16 + c) : 32'(16 - c), 1'b0);
      wr(tecu_pkg::ADDR_START, 32'h00);
    end
    // End value in both directions, with pulse output and service
    for (int u = 0; u < 2; u++) begin
      if (in_pin[2] !== 1'b0) u_pins.toggle_in(2, 6);
      v = u ? 16'hFFFE : 16'h0001;
      wr(tmr_a(2), {16'h0000, v});
      wr(mode_a(2), 32'h05);
      wr(tecu_pkg::ADDR_UPDOWN, {29'h0, u[0], 2'h0});
      wr(tecu_pkg::ADDR_START, 32'h04);
      repeat (4) u_pins.toggle_in(2, 6);
      rd(tmr_a(2), {16'h0000, v}, 1'b0);
      check("request and pin", 33'h3, {31'h0, irq_req[2], pin_drv[2]});
      irq_ack[2] <= 1'b1;
      @(posedge clk_sys_in);
      irq_ack[2] <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      check("serviced request", 33'h0, {32'h0, irq_req[2]});
      wr(tecu_pkg::ADDR_START, 32'h00);
    end
    // Direction from the output pin; pulse output stays off
    u_pins.set_dir(3, 1'b1);
    wr(tmr_a(3), 32'h0010);
    wr(mode_a(3), 32'h11);
    wr(tecu_pkg::ADDR_START, 32'h08);
    repeat (2) u_pins.toggle_in(3, 6);
    rd(tmr_a(3), 32'h0011, 1'b0);
    u_pins.set_dir(3, 1'b0);
    repeat (4) u_pins.toggle_in(3, 6);
    rd(tmr_a(3), 32'h000F, 1'b0);
    repeat (4) @(posedge clk_sys_in);
    check("pending reads", 33'h0, 33'(exp_q.size()));
    give_verdict();
  end
endmodule
